// >>> core/pbw_bridge.v
// cpu to peripheral bus bridge that stretches special register accesses
`include "pbw_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module pbw_bridge #(
  parameter CFG_W = `PBW_CFG_W
) (
  // clock, reset and clock enable
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  // system_wait_config write port and readback
  input wire cfgWrite,
  input wire [CFG_W-1:0] cfgData,
  output reg [CFG_W-1:0] systemWaitConfig,
  // cpu access request
  input wire accReq,
  input wire accWrite,
  input wire [3:0] accClass,
  // cpu access answer
  output wire cpuWait,
  output wire accDone,
  output reg [7:0] accCycles,
  output reg [2:0] accFactor,
  output reg accContinuous,
  // peripheral side state
  input wire periphClk,
  input wire watchdogRunning,
  input wire rtoOutputEnable,
  // cpu clock source state
  input wire subclockMainStopped,
  input wire internalOscActive,
  // stall that only reset clears
  output wire accHung
);

  //////////////////////////////////////////////////////////////////////////
  // states and storage

  // binary codes; 2'b11 is never entered and falls back to idle
  // the hang state has no exit but reset, since nothing on the peripheral
  // side can finish an access once the cpu runs from a prohibited clock
  localparam ST_IDLE = 2'b00;
  localparam ST_BUSY = 2'b01;
  localparam ST_HANG = 2'b10;

  reg [1:0] stateQ;
  reg [1:0] stateD;
  reg [7:0] cntQ;
  reg [7:0] cntD;
  reg contWinQ;
  reg [3:0] lastWrClassQ;
  reg lastWrValidQ;

  // decoded terms and handshake conditions
  wire periphPhase;
  wire [3:0] termI;
  wire [3:0] termJ;
  wire isContinuous;
  wire prohibitedClock;
  wire reqTaken;

  // combinational results for the request now presented
  reg [2:0] factorK;
  reg [7:0] totalCycles;

  //////////////////////////////////////////////////////////////////////////
  // peripheral clock phase

  // the peripheral clock is foreign to sys_clk, so only its settled level
  // is used to judge where in its period an access starts
  // a change is accepted only once the last two stages agree
  pbw_sync #(
    .WIDTH(1)
  ) uPhaseSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(periphClk),
    .syncOut(periphPhase)
  );

  //////////////////////////////////////////////////////////////////////////
  // system wait configuration

  // written only between accesses so a running access keeps its length
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      systemWaitConfig <= `PBW_CFG_RESET;
    end else if (clkEn && cfgWrite && stateQ == ST_IDLE && !accReq) begin
      systemWaitConfig <= cfgData;
    end
  end

  // limitation: j is taken as the whole four-bit field, so values above
  // one are honoured rather than refused
  assign termI = systemWaitConfig[`PBW_CFG_I_MSB:`PBW_CFG_I_LSB];
  assign termJ = systemWaitConfig[`PBW_CFG_J_MSB:`PBW_CFG_J_LSB];

  //////////////////////////////////////////////////////////////////////////
  // continuous compare write detection

  // a compare write is continuous when it follows directly on a completed
  // write to the same compare register class
  // any access in between closes the window, because it lasts one cycle
  assign isContinuous = accWrite && contWinQ && lastWrValidQ &&
                        (lastWrClassQ == accClass);

  //////////////////////////////////////////////////////////////////////////
  // factor k selection

  // alternate values: low phase takes the smaller, high phase the larger;
  // the phase seen is up to four cycles old, which the larger k covers
  // reads of write-only classes and writes of read-only ones keep k at 0
  always @* begin
    factorK = `PBW_K_NONE;
    case (accClass)
      `PBW_CLS_TP_CNT: begin
        if (!accWrite) begin
          factorK = periphPhase ? `PBW_K_RD_HI : `PBW_K_RD_LO;
        end
      end
      `PBW_CLS_TP_CMP: begin
        if (!accWrite) begin
          factorK = periphPhase ? `PBW_K_RD_HI : `PBW_K_RD_LO;
        end else if (isContinuous) begin
          factorK = periphPhase ? `PBW_K_WR_HI : `PBW_K_WR_LO;
        end
      end
      `PBW_CLS_TQ_CNT: begin
        if (!accWrite) begin
          factorK = periphPhase ? `PBW_K_RD_HI : `PBW_K_RD_LO;
        end
      end
      `PBW_CLS_TQ_CMP: begin
        if (!accWrite) begin
          factorK = periphPhase ? `PBW_K_RD_HI : `PBW_K_RD_LO;
        end else if (isContinuous) begin
          factorK = periphPhase ? `PBW_K_WR_HI : `PBW_K_WR_LO;
        end
      end
      `PBW_CLS_WDOG_MODE: begin
        if (accWrite && watchdogRunning) begin
          factorK = `PBW_K_WDOG;
        end
      end
      `PBW_CLS_RTO_BUF: begin
        if (accWrite && !rtoOutputEnable) begin
          factorK = `PBW_K_RTO;
        end
      end
      `PBW_CLS_ADC: begin
        if (!accWrite) begin
          factorK = periphPhase ? `PBW_K_RD_HI : `PBW_K_RD_LO;
        end
      end
      `PBW_CLS_IIC_STAT: begin
        if (!accWrite) begin
          factorK = `PBW_K_IIC;
        end
      end
      `PBW_CLS_CHECKSUM: begin
        if (accWrite) begin
          factorK = `PBW_K_CRC;
        end
      end
      default: begin
        factorK = `PBW_K_NONE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // access length

  // special waits ride on top of the configured i and j waits
  // worst case 3 + 15 + 15 + 17 * 4 = 101 still fits the eight-bit count
  always @* begin
    totalCycles = `PBW_BASE_CYCLES + {4'h0, termI} + {4'h0, termJ} +
                  (`PBW_J_MUL_BASE + {4'h0, termJ}) * {5'h00, factorK};
  end

  //////////////////////////////////////////////////////////////////////////
  // access sequencer

  // plain accesses are still served on the prohibited clock sources; a special
  // access there locks the stall because no peripheral edge will free it
  assign prohibitedClock = subclockMainStopped | internalOscActive;
  assign reqTaken = (stateQ == ST_IDLE) && accReq;

  // cntQ holds the cycles still to go; accDone marks the last one so the
  // cpu can drop its request on the following edge
  always @* begin
    stateD = stateQ;
    cntD = cntQ;
    case (stateQ)
      ST_IDLE: begin
        if (accReq) begin
          if (prohibitedClock && factorK != `PBW_K_NONE) begin
            stateD = ST_HANG;
          end else begin
            stateD = ST_BUSY;
            cntD = totalCycles - 8'h01;
          end
        end
      end
      ST_BUSY: begin
        if (cntQ == 8'h01) begin
          stateD = ST_IDLE;
          cntD = 8'h00;
        end else begin
          cntD = cntQ - 8'h01;
        end
      end
      ST_HANG: begin
        stateD = ST_HANG;
      end
      default: begin
        stateD = ST_IDLE;
        cntD = 8'h00;
      end
    endcase
  end

  // state and count advance only on enabled edges
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateQ <= ST_IDLE;
      cntQ <= 8'h00;
    end else if (clkEn) begin
      stateQ <= stateD;
      cntQ <= cntD;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // continuous write history

  // the window is open only in the cycle right after a completed access
  // the class is kept for every taken access, the valid flag only for
  // compare writes, so a read or another class breaks a continuous run
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      contWinQ <= 1'b0;
      lastWrClassQ <= `PBW_CLS_PLAIN;
      lastWrValidQ <= 1'b0;
    end else if (clkEn) begin
      contWinQ <= accDone;
      if (reqTaken) begin
        lastWrValidQ <= accWrite && (accClass == `PBW_CLS_TP_CMP ||
                                     accClass == `PBW_CLS_TQ_CMP);
        lastWrClassQ <= accClass;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reported figures of the current access

  // latched at the taking edge, so a hung access still shows its factor
  // and the figures stay readable after the stall ends
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      accCycles <= 8'h00;
      accFactor <= `PBW_K_NONE;
      accContinuous <= 1'b0;
    end else if (clkEn && reqTaken) begin
      accCycles <= totalCycles;
      accFactor <= factorK;
      accContinuous <= isContinuous;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cpu handshake

  // stall covers the request cycle too, so the next instruction waits
  // trade-off: a combinational stall costs a path from accReq to the cpu
  // but wastes no cycle at the start of the access
  assign cpuWait = accReq | (stateQ != ST_IDLE);
  assign accDone = (stateQ == ST_BUSY) && (cntQ == 8'h01);
  assign accHung = (stateQ == ST_HANG);

endmodule

`default_nettype wire

// >>> core/pbw_defs.vh
// constants of the peripheral bus access wait bridge
`ifndef PBW_DEFS_VH
`define PBW_DEFS_VH

// system wait configuration fields and reset value
`define PBW_CFG_W 8
`define PBW_CFG_I_MSB 7
`define PBW_CFG_I_LSB 4
`define PBW_CFG_J_MSB 3
`define PBW_CFG_J_LSB 0
`define PBW_CFG_RESET 8'h77

// access length terms: 3 + i + j + (2 + j) * k
`define PBW_BASE_CYCLES 8'h03
`define PBW_J_MUL_BASE 8'h02

// register class codes presented with each access
`define PBW_CLS_PLAIN 4'h0
`define PBW_CLS_TP_CNT 4'h1
`define PBW_CLS_TP_CMP 4'h2
`define PBW_CLS_TQ_CNT 4'h3
`define PBW_CLS_TQ_CMP 4'h4
`define PBW_CLS_WDOG_MODE 4'h5
`define PBW_CLS_RTO_BUF 4'h6
`define PBW_CLS_ADC 4'h7
`define PBW_CLS_IIC_STAT 4'h8
`define PBW_CLS_CHECKSUM 4'h9

// factor k values
`define PBW_K_NONE 3'h0
`define PBW_K_RD_LO 3'h1
`define PBW_K_RD_HI 3'h2
`define PBW_K_WR_LO 3'h3
`define PBW_K_WR_HI 3'h4
`define PBW_K_WDOG 3'h3
`define PBW_K_RTO 3'h1
`define PBW_K_IIC 3'h1
`define PBW_K_CRC 3'h1

`endif

// >>> core/pbw_sync.v
// three-stage synchroniser that reports a level once two stages agree
`timescale 1ns/10ps
`default_nettype none

module pbw_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  // asynchronous level in, settled level out
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1Q;
  reg [WIDTH-1:0] stage2Q;
  reg [WIDTH-1:0] stage3Q;

  // stage1 feeds only stage2; the output moves when stage2 and 3 agree
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1Q <= {WIDTH{1'b0}};
      stage2Q <= {WIDTH{1'b0}};
      stage3Q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
      if (stage2Q == stage3Q) begin
        syncOut <= stage3Q;
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/pbw_checker.sv
// assertions on the ports of the peripheral access wait bridge
`timescale 1ns/10ps
`default_nettype none
`include "pbw_defs.vh"
module pbw_checker #(
  parameter CFG_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // request and state inputs
  input wire logic accReq,
  input wire logic accWrite,
  input wire logic [3:0] accClass,
  input wire logic watchdogRunning,
  input wire logic rtoOutputEnable,
  input wire logic subclockMainStopped,
  input wire logic internalOscActive,
  // answers
  input wire logic [CFG_W-1:0] systemWaitConfig,
  input wire logic cpuWait,
  input wire logic accDone,
  input wire logic [7:0] accCycles,
  input wire logic [2:0] accFactor,
  input wire logic accContinuous,
  input wire logic accHung
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // cycles into the access; frozen with the design while clkEn is low
  logic [7:0] waitCnt_q;
  logic [7:0] expLen;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) waitCnt_q <= 8'h00;
    else if (!clkEn) waitCnt_q <= waitCnt_q;
    else if (accDone || !cpuWait) waitCnt_q <= 8'h00;
    else waitCnt_q <= waitCnt_q + 8'h01;
  end
  // length from i, j and the chosen k
  assign expLen = 8'h03 + systemWaitConfig[7:4] + systemWaitConfig[3:0]
    + (8'h02 + systemWaitConfig[3:0]) * accFactor;
  // a request taken in an idle cycle
  sequence take_s;
    clkEn && accReq && waitCnt_q == 8'h00 && !accHung;
  endsequence
  done_count_a:
    assert property (accDone |-> waitCnt_q == accCycles - 8'h01)
    else $error("bad access length");
  len_formula_a:
    assert property (accDone |-> accCycles == expLen)
    else $error("bad length formula");
  stall_release_a:
    assert property ($fell(cpuWait) |-> $past(accDone))
    else $error("stall dropped early");
  read_factor_a:
    assert property (take_s ##0 (!accWrite && accClass inside
      {`PBW_CLS_TP_CNT, `PBW_CLS_TP_CMP, `PBW_CLS_TQ_CNT, `PBW_CLS_TQ_CMP,
      `PBW_CLS_ADC})
      |=> accFactor inside {`PBW_K_RD_LO, `PBW_K_RD_HI})
    else $error("bad read factor");
  cmp_write_a:
    assert property (take_s ##0 (accWrite && accClass inside
      {`PBW_CLS_TP_CMP, `PBW_CLS_TQ_CMP}) |=> (accContinuous ?
      accFactor inside {`PBW_K_WR_LO, `PBW_K_WR_HI} : accFactor == 3'h0))
    else $error("bad compare write factor");
  wdog_write_a:
    assert property (take_s ##0 (accWrite && watchdogRunning &&
      accClass == `PBW_CLS_WDOG_MODE) |=> accFactor == `PBW_K_WDOG)
    else $error("bad watchdog factor");
  rto_write_a:
    assert property (take_s ##0 (accWrite && !rtoOutputEnable &&
      accClass == `PBW_CLS_RTO_BUF) |=> accFactor == `PBW_K_RTO)
    else $error("bad rto factor");
  plain_nowait_a:
    assert property (take_s ##0 (accClass == `PBW_CLS_PLAIN)
      |=> accFactor == `PBW_K_NONE)
    else $error("plain access waited");
  hang_hold_a:
    assert property (accHung |=> accHung && cpuWait && !accDone)
    else $error("hang released");
  hang_cause_a:
    assert property ($rose(accHung) |-> accFactor != 3'h0 &&
      ($past(subclockMainStopped) || $past(internalOscActive)))
    else $error("hang without cause");
  freeze_hold_a:
    assert property (!clkEn |=> $stable(accCycles) && $stable(accFactor)
      && $stable(accHung) && $stable(systemWaitConfig))
    else $error("state moved while frozen");
endmodule
bind pbw_bridge pbw_checker #(.CFG_W(CFG_W)) chk (.sys_clk(sys_clk),
  .rst(rst), .clkEn(clkEn), .accReq(accReq), .accWrite(accWrite),
  .accClass(accClass), .watchdogRunning(watchdogRunning),
  .rtoOutputEnable(rtoOutputEnable),
  .subclockMainStopped(subclockMainStopped),
  .internalOscActive(internalOscActive),
  .systemWaitConfig(systemWaitConfig), .cpuWait(cpuWait),
  .accDone(accDone), .accCycles(accCycles), .accFactor(accFactor),
  .accContinuous(accContinuous), .accHung(accHung));
`default_nettype wire

// >>> test/pbw_periph_model.sv
// far side model: peripheral clock and unit status levels
`timescale 1ns/10ps
`default_nettype none
module pbw_periph_model (
  // control from the bench
  input wire logic rst,
  input wire logic wdogHalt,
  input wire logic rtoEnable,
  // peripheral state
  output var logic periphClk,
  output var logic watchdogRunning,
  output var logic rtoOutputEnable
);
  // free running, phase unrelated to the cpu clock
  initial periphClk = 1'b0;
  always #370 periphClk = ~periphClk;
  // watchdog starts at reset release and runs until halted
  assign watchdogRunning = !rst && !wdogHalt;
  assign rtoOutputEnable = rtoEnable;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the peripheral access wait bridge
`timescale 1ns/10ps
`default_nettype none
`include "pbw_defs.vh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cfgWrite = 1'b0;
  logic [7:0] cfgData = 8'h00;
  logic accReq = 1'b0;
  logic accWrite = 1'b0;
  logic [3:0] accClass = 4'h0;
  logic subclockMainStopped = 1'b0;
  logic internalOscActive = 1'b0;
  logic wdogHalt = 1'b0;
  logic rtoEnable = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] curCfg = 8'h77;
  int checks = 0;
  int nMismatch = 0;
  wire periphClk, watchdogRunning, rtoOutputEnable, cpuWait, accDone;
  wire accContinuous, accHung;
  wire [7:0] systemWaitConfig, accCycles;
  wire [2:0] accFactor;
  ////////////////////////////////////////
  // far side and the bridge
  pbw_periph_model periph (.rst(rst), .wdogHalt(wdogHalt),
    .rtoEnable(rtoEnable), .periphClk(periphClk),
    .watchdogRunning(watchdogRunning), .rtoOutputEnable(rtoOutputEnable));
  pbw_bridge dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .cfgWrite(cfgWrite), .cfgData(cfgData),
    .systemWaitConfig(systemWaitConfig), .accReq(accReq),
    .accWrite(accWrite), .accClass(accClass), .cpuWait(cpuWait),
    .accDone(accDone), .accCycles(accCycles), .accFactor(accFactor),
    .accContinuous(accContinuous), .periphClk(periphClk),
    .watchdogRunning(watchdogRunning), .rtoOutputEnable(rtoOutputEnable),
    .subclockMainStopped(subclockMainStopped),
    .internalOscActive(internalOscActive), .accHung(accHung));
  always #50 sys_clk = ~sys_clk;
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // config write while idle, seen the cycle after
  task automatic cfg(input logic [7:0] v);
    cfgWrite = 1'b1;
    cfgData = v;
    @(negedge sys_clk);
    cfgWrite = 1'b0;
    curCfg = v;
    cmp8(systemWaitConfig, v);
  endtask
  // one access; keep holds the request for a back-to-back one
  task automatic acc(input logic wr, input logic [3:0] cls, input int kLo,
    input int kHi, input logic keep);
    int n;
    logic [7:0] lo;
    logic [7:0] hi;
    lo = 8'(3 + curCfg[7:4] + curCfg[3:0] + (2 + curCfg[3:0]) * kLo);
    hi = 8'(3 + curCfg[7:4] + curCfg[3:0] + (2 + curCfg[3:0]) * kHi);
    accReq = 1'b1;
    accWrite = wr;
    accClass = cls;
    n = 1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (accDone !== 1'b1 && n < 300);
    cmp8(8'(n), (8'(n) === hi) ? hi : lo);
    cmp8(accCycles, 8'(n));
    @(negedge sys_clk);
    if (!keep) begin
      accReq = 1'b0;
      @(negedge sys_clk);
    end
  endtask
  task automatic sc_reset_len();
    cmp8(systemWaitConfig, 8'h77);
    acc(1'b0, `PBW_CLS_PLAIN, 0, 0, 1'b0);
  endtask
  task automatic sc_special();
    cfg(8'h12);
    acc(1'b0, `PBW_CLS_TP_CNT, 1, 2, 1'b0);
    acc(1'b0, `PBW_CLS_TP_CMP, 1, 2, 1'b0);
    acc(1'b0, `PBW_CLS_TQ_CNT, 1, 2, 1'b0);
    acc(1'b0, `PBW_CLS_TQ_CMP, 1, 2, 1'b0);
    acc(1'b1, `PBW_CLS_WDOG_MODE, 3, 3, 1'b0);
    acc(1'b1, `PBW_CLS_RTO_BUF, 1, 1, 1'b0);
    acc(1'b0, `PBW_CLS_ADC, 1, 2, 1'b0);
    acc(1'b0, `PBW_CLS_IIC_STAT, 1, 1, 1'b0);
    acc(1'b1, `PBW_CLS_CHECKSUM, 1, 1, 1'b0);
    wdogHalt = 1'b1;
    rtoEnable = 1'b1;
    acc(1'b1, `PBW_CLS_WDOG_MODE, 0, 0, 1'b0);
    acc(1'b1, `PBW_CLS_RTO_BUF, 0, 0, 1'b0);
    wdogHalt = 1'b0;
    rtoEnable = 1'b0;
  endtask
  task automatic sc_continuous();
    cfg(8'h01);
    acc(1'b1, `PBW_CLS_TP_CMP, 0, 0, 1'b1);
    acc(1'b1, `PBW_CLS_TP_CMP, 3, 4, 1'b1);
    cmp8({7'h00, accContinuous}, 8'h01);
    acc(1'b1, `PBW_CLS_TQ_CMP, 0, 0, 1'b1);
    acc(1'b1, `PBW_CLS_TQ_CMP, 3, 4, 1'b0);
    cmp8({7'h00, accContinuous}, 8'h01);
  endtask
  // a low enable holds the access where it stands, then it finishes
  task automatic sc_freeze();
    int n;
    cfg(8'h00);
    accReq = 1'b1;
    accWrite = 1'b0;
    accClass = `PBW_CLS_PLAIN;
    @(negedge sys_clk);
    clkEn = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp8({6'h00, accDone, cpuWait}, 8'h01);
    cmp8(accCycles, 8'h03);
    clkEn = 1'b1;
    n = 0;
    while (accDone !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    cmp8(8'(n), 8'h01);
    @(negedge sys_clk);
    accReq = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic sc_hang();
    cfg(8'h00);
    internalOscActive = 1'b1;
    acc(1'b0, `PBW_CLS_PLAIN, 0, 0, 1'b0);
    internalOscActive = 1'b0;
    subclockMainStopped = 1'b1;
    accReq = 1'b1;
    accClass = `PBW_CLS_TP_CNT;
    accWrite = 1'b0;
    repeat (40) @(negedge sys_clk);
    cmp8({6'h00, accHung, cpuWait}, 8'h03);
    rst = 1'b1;
    accReq = 1'b0;
    subclockMainStopped = 1'b0;
    @(negedge sys_clk);
    rst = 1'b0;
    curCfg = 8'h77;
    cmp8({6'h00, accHung, cpuWait}, 8'h00);
    acc(1'b0, `PBW_CLS_PLAIN, 0, 0, 1'b0);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    sc_reset_len();
    sc_special();
    sc_continuous();
    sc_freeze();
    sc_hang();
    final_report();
  end
  // the run needs well under a thousand cycles
  initial begin
    #500000;
    nMismatch++;
    final_report();
  end
endmodule
`default_nettype wire
